/* File: design/amp_link_pkg.sv */
// shared constants and types for the amplifier two-wire control port and its host
package amp_link_pkg;
	// link timing: system clock 20 MHz, fastest bit rate 400 kbps
	localparam int CLK_NS  = 50;
	localparam int BIT_NS  = 2500;
	// quarter bit in cycles, rounded up so the rate never exceeds 400 kbps
	localparam int QTR_CYC = (BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);

	// fixed upper five bits of the slave address
	localparam logic [4:0] ADDR_FIXED = 5'h1b;

	// device register subaddresses
	localparam logic [7:0] REG_LATCHED_GLOBAL_FAULT  = 8'h00;
	localparam logic [7:0] REG_LATCHED_CHANNEL_FAULT = 8'h01;
	localparam logic [7:0] REG_LATCHED_LOAD_DIAG_LOW = 8'h02;
	localparam logic [7:0] REG_LATCHED_LOAD_DIAG_HI  = 8'h03;
	localparam logic [7:0] REG_TEMP_VOLTAGE_STATUS   = 8'h04;
	localparam logic [7:0] REG_OUTPUT_STATE_STATUS   = 8'h05;
	localparam logic [7:0] REG_MUTE_PLAY_STATUS      = 8'h06;
	localparam logic [7:0] REG_LOAD_DIAG_STATUS      = 8'h07;
	localparam logic [7:0] REG_CHANNEL_GAIN_CTRL     = 8'h08;
	localparam logic [7:0] REG_OVERCURRENT_CTRL      = 8'h09;
	localparam logic [7:0] REG_SWITCH_FREQ_PIN_CTRL  = 8'h0a;
	localparam logic [7:0] REG_DIAG_MASTER_MODE_CTRL = 8'h0b;
	localparam logic [7:0] REG_OUTPUT_STATE_CTRL_A   = 8'h0c;
	localparam logic [7:0] REG_OUTPUT_STATE_CTRL_B   = 8'h0d;
	localparam logic [7:0] REG_DC_DETECT_THRESH_CTRL = 8'h10;
	localparam logic [7:0] REG_THERMAL_SHUTDOWN_STAT = 8'h13;
	// control register slot of the dc threshold, after the six contiguous ones
	localparam logic [2:0] DC_THRESH_SLOT = 3'h6;
	localparam logic [7:0] CTRL_RESET     = 8'h00;

	// host-side apb register offsets
	localparam logic [7:0] HREG_CMD    = 8'h00;
	localparam logic [7:0] HREG_TXDATA = 8'h04;
	localparam logic [7:0] HREG_STATUS = 8'h08;
	localparam logic [7:0] HREG_RXDATA = 8'h0c;
	// command field positions
	localparam int CMD_NACK_BIT = 8;

	// decoded address-select pin levels
	typedef enum logic [1:0] {
		oscillator_leader_setting = 2'b00,
		oscillator_follower_one   = 2'b01,
		oscillator_follower_two   = 2'b10,
		oscillator_follower_three = 2'b11
	} osc_role_t;

	// device link states
	typedef enum logic [2:0] {
		ds_idle = 3'b000,
		ds_rx   = 3'b001,
		ds_ack  = 3'b010,
		ds_tx   = 3'b011,
		ds_mack = 3'b100
	} dev_state_t;

	// meaning of the next byte the device receives
	typedef enum logic [1:0] {
		bk_addr = 2'b00,
		bk_sub  = 2'b01,
		bk_data = 2'b10
	} byte_kind_t;

	// host link commands
	typedef enum logic [2:0] {
		op_none  = 3'b000,
		op_start = 3'b001,
		op_write = 3'b010,
		op_read  = 3'b011,
		op_stop  = 3'b100
	} host_op_t;
endpackage

/* File: design/amp_link_if.sv */
// two-wire link carrier joining the host end and the amplifier end
`timescale 1ns/1ps
interface amp_link_if;
	// host drive of the two wires
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	// device drive of the two wires
	logic s_scl_o;
	logic s_scl_oe;
	logic s_sda_o;
	logic s_sda_oe;
	// resolved wire levels, pull-ups when nobody drives
	logic scl;
	logic sda;

	// wired-and of both parties
	assign scl = (~m_scl_oe | m_scl_o) & (~s_scl_oe | s_scl_o);
	assign sda = (~m_sda_oe | m_sda_o) & (~s_sda_oe | s_sda_o);

	modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
	modport dev (output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe, input scl, sda);
endinterface

/* File: design/amp_ctrl_port.sv */
// amplifier end: two-wire slave giving access to control and status registers
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// How it works
// (RULE1) link works at rates to 400 kbps
// (RULE2) slave only, never holds clock low
// (RULE3) bytes of eight bits, msb first
// (RULE4) receiver acknowledges in the ninth clock
// (RULE5) start and stop detected while clock high
// (RULE6) data changes only while clock low
// (RULE7) acknowledge holds data low whole period
// (RULE8) host sends address, direction, waits acknowledge
// (RULE9) address is 11011 plus select pin value
// (RULE10) no limit on bytes per transfer
// (RULE11) write: address, subaddress, data, all acknowledged
// (RULE12) each written byte stored, subaddress advances
// (RULE13) read: subaddress write, repeated start, data
// (RULE14) acknowledged read bytes advance the subaddress
// (RULE15) final read byte refused, then stop
// (RULE16) host continues after acknowledge, stops at end
// (RULE17) subaddresses 0x00 to 0x07 read only
// (RULE18) control registers 0x08 to 0x0d, 0x10
// (RULE19) subaddress 0x13 reports thermal shutdown state
// (RULE20) low-supply reset releases the link lines
// (RULE21) select pin decodes into four roles
// (RULE22) other addresses get no acknowledge
// (RULE23) unused writes ignored, unused reads zero
module amp_ctrl_port (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// two-wire link
	amp_link_if.dev                     link,
	// supply monitor and address strap
	input  wire logic                   supply_por,
	input  wire logic [1:0]             addr_sel,
	// status inputs from protection and diagnostic circuits
	input  wire logic [7:0][7:0]        ro_status,
	input  wire logic [7:0]             thermal_status,
	// control outputs
	output logic [6:0][7:0]             ctrl_regs,
	output amp_link_pkg::osc_role_t     osc_role
);
	// all state of the port
	typedef struct packed {
		logic [1:0]               scl_sy;  // clock synchroniser
		logic [1:0]               sda_sy;  // data synchroniser
		logic                     scl_p;   // last synced clock
		logic                     sda_p;   // last synced data
		amp_link_pkg::dev_state_t st;      // link state
		amp_link_pkg::byte_kind_t kind;    // meaning of next byte
		logic [3:0]               cnt;     // bit counter
		logic [7:0]               sh;      // shift register
		logic                     rw;      // read transfer active
		logic [7:0]               ptr;     // subaddress pointer
		logic                     drv;     // pulling data low
		amp_link_pkg::osc_role_t  sel;     // captured strap
		logic                     sel_ok;  // strap captured
		logic [6:0][7:0]          ctrl;    // control registers
	} state_t;

	state_t q;  // current state
	state_t d;  // next state

	// slot of a control register, or none
	function automatic logic ctrl_hit(input logic [7:0] a);
		ctrl_hit = (a >= amp_link_pkg::REG_CHANNEL_GAIN_CTRL &&
			a <= amp_link_pkg::REG_OUTPUT_STATE_CTRL_B) ||
			a == amp_link_pkg::REG_DC_DETECT_THRESH_CTRL; // RULE18
	endfunction

	function automatic logic [2:0] ctrl_slot(input logic [7:0] a);
		logic [7:0] off;
		off = a - amp_link_pkg::REG_CHANNEL_GAIN_CTRL;
		if (a == amp_link_pkg::REG_DC_DETECT_THRESH_CTRL)
			ctrl_slot = amp_link_pkg::DC_THRESH_SLOT;
		else
			ctrl_slot = off[2:0];
	endfunction

	// read mux over the whole subaddress space
	function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [6:0][7:0] c);
		if (a <= amp_link_pkg::REG_LOAD_DIAG_STATUS)
			rd_reg = ro_status[a[2:0]]; // RULE17
		else if (ctrl_hit(a))
			rd_reg = c[ctrl_slot(a)]; // RULE18
		else if (a == amp_link_pkg::REG_THERMAL_SHUTDOWN_STAT)
			rd_reg = thermal_status; // RULE19
		else
			rd_reg = 8'h00; // RULE23
	endfunction

	logic scl_s;  // synced clock level
	logic sda_s;  // synced data level
	logic rise;   // clock rising edge
	logic fall;   // clock falling edge
	logic start;  // start or repeated start
	logic stop;   // stop

	// only the second synchroniser stage feeds any logic
	assign scl_s = q.scl_sy[1];
	assign sda_s = q.sda_sy[1];
	assign rise  = scl_s & ~q.scl_p;
	assign fall  = ~scl_s & q.scl_p;
	// data edges while clock stays high frame a transfer
	assign start = scl_s & q.scl_p & q.sda_p & ~sda_s; // RULE5
	assign stop  = scl_s & q.scl_p & ~q.sda_p & sda_s; // RULE5

	// next-state logic
	always_comb
	begin
		d = q;
		// two stages keep the 400 kbps pins out of the clock domain's metastability
		d.scl_sy = {q.scl_sy[0], link.scl}; // RULE1
		d.sda_sy = {q.sda_sy[0], link.sda};
		d.scl_p  = q.scl_sy[1];
		d.sda_p  = q.sda_sy[1];
		// strap is taken once after reset release, never under reset
		if (!q.sel_ok)
		begin
			d.sel    = amp_link_pkg::osc_role_t'(addr_sel); // RULE21
			d.sel_ok = 1'b1;
		end
		if (supply_por)
		begin
			// low supply: everything back to reset, lines released
			d = '0; // RULE20
		end
		else if (start)
		begin
			// a start anywhere restarts address reception
			d.st   = amp_link_pkg::ds_rx;
			d.kind = amp_link_pkg::bk_addr;
			d.cnt  = 4'h0;
			d.rw   = 1'b0;
			d.drv  = 1'b0;
		end
		else if (stop)
		begin
			d.st  = amp_link_pkg::ds_idle;
			d.drv = 1'b0;
		end
		else
		begin
			unique case (q.st)
				amp_link_pkg::ds_idle:
				begin
					// wait for a start
				end
				amp_link_pkg::ds_rx:
				begin
					if (rise && q.cnt < 4'h8)
					begin
						// sample on rising edge, msb first
						d.sh  = {q.sh[6:0], sda_s}; // RULE3 RULE6
						d.cnt = q.cnt + 4'h1;
					end
					else if (fall && q.cnt == 4'h8)
					begin
						// whole byte in: decide and answer in the ninth clock
						d.st  = amp_link_pkg::ds_ack; // RULE4
						d.drv = 1'b1; // RULE7
						unique case (q.kind)
							amp_link_pkg::bk_addr:
							begin
								if (q.sh[7:1] == {amp_link_pkg::ADDR_FIXED, q.sel}) // RULE9
								begin
									d.rw   = q.sh[0];
									d.kind = amp_link_pkg::bk_sub; // RULE11
									if (q.sh[0])
										d.sh = rd_reg(q.ptr, q.ctrl); // RULE13
								end
								else
								begin
									// not ours: stay off the bus
									d.st  = amp_link_pkg::ds_idle; // RULE22
									d.drv = 1'b0;
								end
							end
							amp_link_pkg::bk_sub:
							begin
								d.ptr  = q.sh;
								d.kind = amp_link_pkg::bk_data;
							end
							amp_link_pkg::bk_data:
							begin
								// store, then advance; no byte limit
								if (ctrl_hit(q.ptr))
									d.ctrl[ctrl_slot(q.ptr)] = q.sh; // RULE12 RULE23
								d.ptr = 8'(q.ptr + 8'h01); // RULE10 RULE12
							end
							default:
							begin
								d.st  = amp_link_pkg::ds_idle;
								d.drv = 1'b0;
							end
						endcase
					end
				end
				amp_link_pkg::ds_ack:
				begin
					// acknowledge held until the clock falls again
					if (fall)
					begin
						if (q.rw)
						begin
							// first data bit goes out as the clock falls
							d.st  = amp_link_pkg::ds_tx;
							d.drv = ~q.sh[7]; // RULE3
							d.sh  = {q.sh[6:0], 1'b0};
							d.cnt = 4'h1;
						end
						else
						begin
							d.st  = amp_link_pkg::ds_rx;
							d.drv = 1'b0;
							d.cnt = 4'h0;
						end
					end
				end
				amp_link_pkg::ds_tx:
				begin
					if (fall)
					begin
						if (q.cnt == 4'h8)
						begin
							// release for the host's answer
							d.st  = amp_link_pkg::ds_mack;
							d.drv = 1'b0;
						end
						else
						begin
							d.drv = ~q.sh[7]; // RULE6
							d.sh  = {q.sh[6:0], 1'b0};
							d.cnt = q.cnt + 4'h1;
						end
					end
				end
				amp_link_pkg::ds_mack:
				begin
					if (rise)
					begin
						if (!sda_s)
						begin
							// acknowledged: next subaddress, wait in ack state undriven
							d.ptr = 8'(q.ptr + 8'h01); // RULE14
							d.sh  = rd_reg(8'(q.ptr + 8'h01), q.ctrl);
							d.st  = amp_link_pkg::ds_ack;
						end
						else
						begin
							// refused: last byte, line stays released
							d.st = amp_link_pkg::ds_idle; // RULE15
						end
					end
				end
				default:
				begin
					d.st  = amp_link_pkg::ds_idle;
					d.drv = 1'b0;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	// open-drain outputs; clock is never held
	assign link.s_scl_o  = 1'b0;
	assign link.s_scl_oe = 1'b0; // RULE2
	assign link.s_sda_o  = 1'b0;
	assign link.s_sda_oe = q.drv; // RULE7
	assign ctrl_regs     = q.ctrl;
	assign osc_role      = q.sel;
endmodule

/* File: design/amp_link_host.sv */
// host end: apb-commanded two-wire master that drives the amplifier link
`timescale 1ns/1ps
module amp_link_host (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	// two-wire link
	amp_link_if.host         link
);
	// all state of the host
	typedef struct packed {
		amp_link_pkg::host_op_t op;       // running command
		logic [1:0]             ph;       // quarter within bit
		logic [7:0]             qc;       // cycles within quarter
		logic [3:0]             bc;       // bit within byte
		logic [7:0]             sh;       // shift register
		logic                   nack_cmd; // refuse the byte being read
		logic                   got_nack; // last written byte refused
		logic [7:0]             tx;       // byte to write
		logic [7:0]             rx;       // last byte read
		logic                   scl_low;  // pulling clock low
		logic                   sda_low;  // pulling data low
		logic [1:0]             sda_sy;   // data synchroniser
		logic [31:0]            rdata;    // apb read data
	} hstate_t;

	hstate_t q;  // current state
	hstate_t d;  // next state

	logic       wr_cmd;  // command register written
	logic       qend;    // last cycle of a quarter
	logic       sda_s;   // synced data level
	logic       apply;   // drive settings change this cycle
	logic [2:0] cmd_op;  // raw op field

	assign sda_s  = q.sda_sy[1];
	assign cmd_op = pwdata[2:0];
	assign qend   = q.qc == 8'(amp_link_pkg::QTR_CYC - 1);
	// zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_cmd = psel & penable & pwrite & paddr == amp_link_pkg::HREG_CMD;

	// next-state logic
	always_comb
	begin
		d      = q;
		apply  = 1'b0;
		d.sda_sy = {q.sda_sy[0], link.sda};
		// apb read data is captured in the setup cycle
		if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				amp_link_pkg::HREG_TXDATA: d.rdata = {24'h000000, q.tx};
				amp_link_pkg::HREG_STATUS:
					d.rdata = {30'h00000000, q.got_nack, q.op != amp_link_pkg::op_none};
				amp_link_pkg::HREG_RXDATA: d.rdata = {24'h000000, q.rx};
				default:                   d.rdata = 32'h00000000;
			endcase
		end
		if (psel && penable && pwrite && paddr == amp_link_pkg::HREG_TXDATA)
			d.tx = pwdata[7:0];
		if (q.op == amp_link_pkg::op_none)
		begin
			// a command is taken only while idle; bad op codes are dropped
			if (wr_cmd && cmd_op != 3'h0 && cmd_op <= 3'h4)
			begin
				d.op       = amp_link_pkg::host_op_t'(cmd_op);
				d.nack_cmd = pwdata[amp_link_pkg::CMD_NACK_BIT];
				d.ph       = 2'h0;
				d.qc       = 8'h00;
				d.bc       = 4'h0;
				d.sh       = q.tx;
				apply      = 1'b1;
			end
		end
		else if (!qend)
			d.qc = q.qc + 8'h01;
		else
		begin
			d.qc  = 8'h00;
			d.ph  = q.ph + 2'h1;
			apply = 1'b1;
			// sample at the end of the second clock-high quarter
			if (q.ph == 2'h2 && q.op == amp_link_pkg::op_write && q.bc == 4'h8)
				d.got_nack = sda_s; // RULE4 RULE8 RULE16
			if (q.ph == 2'h2 && q.op == amp_link_pkg::op_read && q.bc < 4'h8)
				d.sh = {q.sh[6:0], sda_s}; // RULE3
			if (q.ph == 2'h3)
			begin
				apply = 1'b0;
				if (q.op == amp_link_pkg::op_start || q.op == amp_link_pkg::op_stop)
					d.op = amp_link_pkg::op_none;
				else if (q.bc == 4'h8)
				begin
					// byte done with clock low, so releasing data is safe
					d.op      = amp_link_pkg::op_none;
					d.sda_low = 1'b0;
					if (q.op == amp_link_pkg::op_read)
						d.rx = q.sh; // RULE13 RULE14
				end
				else
				begin
					d.bc  = q.bc + 4'h1;
					apply = 1'b1;
					if (q.op == amp_link_pkg::op_write)
						d.sh = {q.sh[6:0], 1'b0}; // RULE3 RULE11
				end
			end
		end
		// line drive per command and quarter
		if (apply)
		begin
			unique case (d.op)
				amp_link_pkg::op_start:
				begin
					// data falls while clock high, then clock low
					if (d.ph == 2'h0) d.sda_low = 1'b0; // RULE5
					if (d.ph == 2'h1) d.scl_low = 1'b0;
					if (d.ph == 2'h2) d.sda_low = 1'b1; // RULE5
					if (d.ph == 2'h3) d.scl_low = 1'b1;
				end
				amp_link_pkg::op_stop:
				begin
					// data rises while clock high
					if (d.ph == 2'h0) d.sda_low = 1'b1;
					if (d.ph == 2'h1) d.scl_low = 1'b0;
					if (d.ph == 2'h2) d.sda_low = 1'b0; // RULE5 RULE15 RULE16
				end
				amp_link_pkg::op_write, amp_link_pkg::op_read:
				begin
					// data set a quarter after the clock fell, never while high
					if (d.ph == 2'h0)
					begin
						if (d.bc == 4'h8)
							d.sda_low = d.op == amp_link_pkg::op_read && !d.nack_cmd; // RULE15
						else
							d.sda_low = d.op == amp_link_pkg::op_write && !d.sh[7]; // RULE6
					end
					if (d.ph == 2'h1) d.scl_low = 1'b0; // RULE1
					if (d.ph == 2'h3) d.scl_low = 1'b1;
				end
				default:
				begin
					// idle: keep drives
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	// open-drain outputs
	assign link.m_scl_o  = 1'b0;
	assign link.m_scl_oe = q.scl_low;
	assign link.m_sda_o  = 1'b0;
	assign link.m_sda_oe = q.sda_low;
	assign prdata        = q.rdata;
endmodule

/* File: testbench/amp_link_monitor.sv */
// checker of link timing between the host end and the amplifier end
`timescale 1ns/1ps
module amp_link_monitor (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// link signals
	input  wire logic                    scl,
	input  wire logic                    sda,
	input  wire logic                    m_scl_oe,
	input  wire logic                    m_sda_oe,
	input  wire logic                    s_scl_oe,
	input  wire logic                    s_sda_oe,
	// decoded strap of the device
	input  wire amp_link_pkg::osc_role_t osc_role
);
	logic [3:0] cnt_q; // clock rises since start, saturating
	logic [7:0] sh_q;  // last eight bits sampled at clock rises, the first byte after start when cnt_q is 8
	logic [7:0] gap_q; // cycles since the last clock rise
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// start and stop: data moves while clock stays high
	sequence start_s; scl && $past(scl) && $fell(sda); endsequence
	sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
	// helper counters; gap starts saturated so the first rise is not judged
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 4'h0;
			sh_q  <= 8'h00;
			gap_q <= 8'hff;
		end
		else
		begin
			gap_q <= $rose(scl) ? 8'h00 : gap_q + {7'h0, gap_q != 8'hff};
			if (scl && $past(scl) && $fell(sda))
				cnt_q <= 4'h0;
			else if ($rose(scl))
			begin
				cnt_q <= cnt_q + {3'h0, cnt_q != 4'hf};
				sh_q  <= {sh_q[6:0], sda};
			end
		end
	end
	slave_no_clk_a: assert property (!s_scl_oe)
		else $error("device pulled the clock line");
	dev_stable_a: assert property ($changed(s_sda_oe) |-> !scl)
		else $error("device moved data while clock high");
	ack_hold_a: assert property (scl && s_sda_oe |=> s_sda_oe || !scl)
		else $error("device let go of data inside a high clock");
	addr_ack_a:
		assert property ($rose(scl) && cnt_q == 4'h8 |->
			s_sda_oe == (sh_q[7:1] == {amp_link_pkg::ADDR_FIXED, osc_role}))
		else $error("address acknowledge wrong");
	addr_quiet_a: assert property (start_s |=> !s_sda_oe [*8])
		else $error("device drove data during address byte");
	stop_free_a: assert property (stop_s |=> !s_sda_oe [*8])
		else $error("device drove data after stop");
	host_idle_a: assert property (stop_s |-> (!m_scl_oe && !m_sda_oe) [*4])
		else $error("host kept a line after stop");
	bit_rate_a: assert property ($rose(scl) |-> gap_q >= 8'h31)
		else $error("clock faster than the top bit rate");
endmodule

/* File: testbench/amp_i2c_slave_register_port_tb_top.sv */
// self-checking bench joining the host end and the amplifier end
`timescale 1ns/1ps
module amp_i2c_slave_register_port_tb_top;
	logic                    clk, rst, supply_por;  // clock, resets
	logic [1:0]              addr_sel;              // strap value
	logic                    psel, penable, pwrite; // apb control
	logic [7:0]              paddr;
	logic [31:0]             pwdata, prdata, last_rd;
	logic                    pready;
	logic [7:0][7:0]         ro_status;             // device status inputs
	logic [7:0]              thermal_status;
	logic [6:0][7:0]         ctrl_regs;             // device control outputs
	amp_link_pkg::osc_role_t osc_role;
	logic                    res_v;                 // a result appears
	logic [31:0]             res_d;
	string                   res_n;                 // name of the result
	logic [31:0]             exp_q [$];             // expected notes
	logic [7:0]              dat [0:15];            // bytes sent
	logic [7:0]              ex [0:31];             // bytes expected back
	logic [1:0]              sv;
	int                      n_mismatch, n_checks, cyc;

	amp_link_if link ();
	amp_ctrl_port u_amp_ctrl_port (.clk(clk), .rst(rst), .link(link),
		.supply_por(supply_por), .addr_sel(addr_sel), .ro_status(ro_status),
		.thermal_status(thermal_status), .ctrl_regs(ctrl_regs), .osc_role(osc_role));
	amp_link_host u_amp_link_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .link(link));
	amp_link_monitor u_amp_link_monitor (.clk(clk), .rst(rst), .scl(link.scl),
		.sda(link.sda), .m_scl_oe(link.m_scl_oe), .m_sda_oe(link.m_sda_oe),
		.s_scl_oe(link.s_scl_oe), .s_sda_oe(link.s_sda_oe), .osc_role(osc_role));

	// verdict and end of run
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
		n_checks++;
		if (seen !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, seen);
		end
	endtask
	// watcher: each result against the oldest note
	always @(posedge clk)
		if (res_v === 1'b1)
			check(res_n, res_d, exp_q.pop_front());
	// one edge of valid, then one quiet edge so valid never toggles twice in a step
	task automatic see(input string n, input logic [31:0] v);
		res_n <= n;
		res_d <= v;
		res_v <= 1'b1;
		@(posedge clk);
		res_v <= 1'b0;
		@(posedge clk);
	endtask
	// one apb transfer; request held until pready seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		last_rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
		see("apb read", last_rd);
	endtask
	// link command, then poll busy; no command is sent while busy
	task automatic op(input logic [2:0] o, input logic nk);
		apb(1'b1, amp_link_pkg::HREG_CMD, {23'h0, nk, 5'h0, o});
		last_rd = 32'h1;
		while (last_rd[0] !== 1'b0)
			apb(1'b0, amp_link_pkg::HREG_STATUS, 32'h0);
	endtask
	task automatic sendb(input logic [7:0] b, input logic nak);
		apb(1'b1, amp_link_pkg::HREG_TXDATA, {24'h0, b});
		rd_chk(amp_link_pkg::HREG_TXDATA, {24'h0, b});
		op(amp_link_pkg::op_write, 1'b0);
		rd_chk(amp_link_pkg::HREG_STATUS, {30'h0, nak, 1'b0});
	endtask
	task automatic head(input logic [1:0] s, input logic rw, input logic nak);
		op(amp_link_pkg::op_start, 1'b0);
		sendb({amp_link_pkg::ADDR_FIXED, s, rw}, nak);
	endtask
	// write frame of n data bytes from sub
	task automatic wr_seq(input logic [7:0] sub, input int n);
		head(addr_sel, 1'b0, 1'b0);
		sendb(sub, 1'b0);
		for (int i = 0; i < n; i++)
			sendb(dat[i], 1'b0);
		op(amp_link_pkg::op_stop, 1'b0);
	endtask
	// read frame: subaddress write, repeated start, n bytes, last refused
	task automatic rd_seq(input logic [7:0] sub, input int n);
		head(addr_sel, 1'b0, 1'b0);
		sendb(sub, 1'b0);
		head(addr_sel, 1'b1, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			op(amp_link_pkg::op_read, i == n - 1);
			rd_chk(amp_link_pkg::HREG_RXDATA, {24'h0, ex[i]});
		end
		op(amp_link_pkg::op_stop, 1'b0);
	endtask
	// expected byte at a subaddress after the sequential write from 0x06
	function automatic logic [7:0] expv(input int j);
		if (j < 8)
			return ro_status[j[2:0]];
		if (j < 14)
			return dat[j - 6];
		if (j == 16)
			return dat[10];
		if (j == 19)
			return thermal_status;
		return 8'h00;
	endfunction

	// bench clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_mismatch++;
			conclude();
		end
	end
	// main sequence
	initial
	begin
		rst = 1'b1;
		supply_por = 1'b0;
		addr_sel = 2'b01;
		{psel, penable, pwrite, res_v} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		res_d = 32'h0;
		void'($urandom(32'h222f));
		ro_status = {$urandom(), $urandom()};
		thermal_status = 8'($urandom());
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		// sequential write over read-only, control and unused places
		for (int i = 0; i < 11; i++)
			dat[i] = 8'($urandom());
		wr_seq(8'h06, 11);
		for (int k = 0; k < 6; k++)
		begin
			exp_q.push_back({24'h0, dat[k + 2]});
			see("control register", {24'h0, ctrl_regs[k]});
		end
		exp_q.push_back({24'h0, dat[10]});
		see("dc threshold register", {24'h0, ctrl_regs[6]});
		for (int j = 0; j < 20; j++)
			ex[j] = expv(j);
		rd_seq(8'h00, 20);
		$display("test sequential write and read done");
		// every strap value, supply reset, foreign address refused
		for (int s = 0; s < 4; s++)
		begin
			sv = s[1:0];
			addr_sel <= sv;
			supply_por <= 1'b1;
			repeat (2) @(posedge clk);
			supply_por <= 1'b0;
			repeat (4) @(posedge clk);
			exp_q.push_back({30'h0, sv});
			see("strap role", {30'h0, osc_role});
			ex[0] = amp_link_pkg::CTRL_RESET;
			rd_seq(8'h08, 1);
			head(sv + 2'h1, 1'b0, 1'b1);
			dat[0] = 8'($urandom());
			wr_seq(8'h08, 1);
			ex[0] = dat[0];
			rd_seq(8'h08, 1);
			$display("test strap %0d done", s);
		end
		conclude();
	end
endmodule
